// *** src/mfh_pkg.sv ***
// Shared constants, types and functions of the function dispatcher.
// Assumes a single 50 MHz clock; this package holds no registers of its own.
package mfh_pkg;

	// ********************************************************************
	// Timing
	// ********************************************************************
	localparam int CLK_HZ      = 50_000_000;
	localparam int TICK_MS     = 1;
	localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
	localparam int MS_PER_S    = 1000;
	localparam int FAST_S      = 1;
	localparam int HARM_S      = 3;
	localparam int SLOW_S      = 5;

	// ********************************************************************
	// Function codes and frame limits
	// ********************************************************************
	localparam logic [7:0] FC_RD_HOLD    = 8'h03;
	localparam logic [7:0] FC_RD_INPUT   = 8'h04;
	localparam logic [7:0] FC_MEI        = 8'h2b;
	localparam logic [7:0] FC_SCATTER    = 8'h64;
	localparam logic [7:0] SUB_IDENT     = 8'h0e;
	localparam logic [7:0] SUB_GET_TIME  = 8'h0f;
	localparam logic [7:0] SUB_SET_TIME  = 8'h10;
	localparam logic [7:0] SUB_SCATTER   = 8'h04;
	localparam logic [7:0] EXC_FLAG      = 8'h80;
	localparam logic [7:0] EXC_ILL_FUNC  = 8'h01;
	localparam logic [7:0] EXC_ILL_VALUE = 8'h03;
	localparam logic [7:0] BCAST_ADDR    = 8'h00;
	localparam logic [7:0] ADDR_LAST     = 8'hf7;
	localparam logic [8:0] FRAME_MAX     = 9'h100;
	localparam logic [7:0] MAX_READ      = 8'h7d;
	localparam logic [7:0] MAX_SCATTER   = 8'h64;
	localparam logic [7:0] SCAT_FIXED    = 8'h02;
	localparam logic [7:0] SCAT_MIN_LEN  = 8'h04;
	localparam logic [7:0] SCAT_FIRST    = 8'h05;
	localparam logic [15:0] CRC_INIT     = 16'hffff;
	localparam logic [15:0] CRC_POLY     = 16'ha001;

	// ********************************************************************
	// Reply layout
	// ********************************************************************
	localparam logic [2:0] HDR_SHORT   = 3'h3;
	localparam logic [2:0] HDR_MEI     = 3'h4;
	localparam logic [2:0] HDR_SCAT    = 3'h5;
	localparam logic [3:0] BODY_TIME   = 4'h8;
	localparam logic [3:0] BODY_IDENT  = 4'ha;
	localparam logic [7:0] ID_CONFORM  = 8'h01;
	localparam logic [7:0] ID_NOBJ     = 8'h01;
	localparam logic [7:0] ID_OBJ_LEN  = 8'h04;
	localparam int         FIFO_W      = 9;
	localparam int         FIFO_DEPTH  = 16;

	// ********************************************************************
	// Calendar
	// ********************************************************************
	localparam logic [15:0] MS_LAST    = 16'hea5f;
	localparam logic [7:0]  MIN_LAST   = 8'h3b;
	localparam logic [7:0]  HOUR_LAST  = 8'h17;
	localparam logic [7:0]  MONTH_LAST = 8'h0c;
	localparam logic [7:0]  YEAR_LAST  = 8'h63;

	typedef struct packed {
		logic [7:0]  year;
		logic [7:0]  month;
		logic [7:0]  day;
		logic [7:0]  hour;
		logic [7:0]  minute;
		logic [15:0] msec;
	} mfh_cal_s;

	localparam mfh_cal_s CAL_RESET = '{8'h00, 8'h01, 8'h01, 8'h00, 8'h00,
		16'h0000};

	typedef enum logic [8:0] {
		S_IDLE   = 9'h001,
		S_DECODE = 9'h002,
		S_HDR    = 9'h004,
		S_FETCH  = 9'h008,
		S_WHI    = 9'h010,
		S_WLO    = 9'h020,
		S_BODY   = 9'h040,
		S_CRCL   = 9'h080,
		S_CRCH   = 9'h100
	} mfh_state_e;

	function automatic logic [7:0] days_in_month(input logic [7:0] year,
		input logic [7:0] month);
		logic [7:0] d;
		d = 8'h1f;
		if (month == 8'h04 || month == 8'h06 || month == 8'h09 ||
			month == 8'h0b)
			d = 8'h1e;
		else if (month == 8'h02)
			d = (year[1:0] == 2'b00) ? 8'h1d : 8'h1c;
		return d;
	endfunction

	function automatic logic cal_valid(input mfh_cal_s c);
		return c.year <= YEAR_LAST && c.month != 8'h00 &&
			c.month <= MONTH_LAST && c.day != 8'h00 &&
			c.day <= days_in_month(c.year, c.month) &&
			c.hour <= HOUR_LAST && c.minute <= MIN_LAST &&
			c.msec <= MS_LAST;
	endfunction

	function automatic logic [15:0] crc_step(input logic [15:0] crc,
		input logic [7:0] data);
		logic [15:0] c;
		c = crc ^ {8'h00, data};
		for (int i = 0; i < 8; i++)
			c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
		return c;
	endfunction

endpackage

// *** src/mfh_stream_if.sv ***
// Byte stream with valid and ready between the dispatcher's own modules.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface mfh_stream_if #(parameter int W = 9);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

// *** src/mfh_fifo.sv ***
// Reply FIFO, first word falls through to the read side.
// Assumes one clock; the reader may stall as long as it likes.
`timescale 1ns/1ps
module mfh_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 16
) (
	// System
	input wire logic clock,
	input wire logic resetn,
	// Fill and drain sides
	mfh_stream_if.snk wr,
	mfh_stream_if.src rd
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [0:DEPTH-1];
	logic [AW:0]      wptr;
	logic [AW:0]      rptr;

	wire full  = (wptr[AW] != rptr[AW]) && (wptr[AW-1:0] == rptr[AW-1:0]);
	wire empty = (wptr == rptr);
	wire do_wr = wr.valid && !full;
	wire do_rd = rd.ready && !empty;

	assign wr.ready = !full;
	assign rd.valid = !empty;
	assign rd.data  = mem[rptr[AW-1:0]];

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			wptr <= '0;
			rptr <= '0;
		end
		else
		begin
			if (do_wr)
				wptr <= wptr + 1'b1;
			if (do_rd)
				rptr <= rptr + 1'b1;
		end
	end

	always_ff @(posedge clock)
	begin
		if (do_wr)
			mem[wptr[AW-1:0]] <= wr.data;
	end
endmodule

// *** src/mfh_clock.sv ***
// Calendar keeping and measurement refresh strobes.
// Assumes one clock; the millisecond divider length is a parameter.
`timescale 1ns/1ps
module mfh_clock #(
	parameter int TICK_CYCLES = mfh_pkg::TICK_CYCLES
) (
	// System
	input  wire logic             clock,
	input  wire logic             resetn,
	// Calendar load and value
	input  wire logic             load,
	input  wire mfh_pkg::mfh_cal_s load_rec,
	output mfh_pkg::mfh_cal_s      now,
	// Refresh strobes
	output logic                  tick_fast,
	output logic                  tick_harm,
	output logic                  tick_slow
);
	logic [31:0]       div;
	logic [9:0]        ms_cnt;
	logic [1:0]        sec3;
	logic [2:0]        sec5;
	mfh_pkg::mfh_cal_s next_now;

	wire ms_tick  = (div == 32'(TICK_CYCLES - 1));
	wire sec_tick = ms_tick && (ms_cnt == 10'(mfh_pkg::MS_PER_S - 1));
	wire harm_hit = (sec3 == 2'(mfh_pkg::HARM_S - 1));
	wire slow_hit = (sec5 == 3'(mfh_pkg::SLOW_S - 1));

	// ********************************************************************
	// Calendar advance; year counts from 2000 and wraps after 2099.
	// ********************************************************************
	always_comb
	begin
		next_now = now;
		if (load)
			next_now = load_rec;
		else if (ms_tick)
		begin
			next_now.msec = now.msec + 16'h0001;
			if (now.msec == mfh_pkg::MS_LAST)
			begin
				next_now.msec = 16'h0000;
				next_now.minute = now.minute + 8'h01;
				if (now.minute == mfh_pkg::MIN_LAST)
				begin
					next_now.minute = 8'h00;
					next_now.hour = now.hour + 8'h01;
					if (now.hour == mfh_pkg::HOUR_LAST)
					begin
						next_now.hour = 8'h00;
						next_now.day = now.day + 8'h01;
						if (now.day == mfh_pkg::days_in_month(now.year,
							now.month))
						begin
							next_now.day = 8'h01;
							next_now.month = now.month + 8'h01;
							if (now.month == mfh_pkg::MONTH_LAST)
							begin
								next_now.month = 8'h01;
								next_now.year = (now.year ==
									mfh_pkg::YEAR_LAST) ? 8'h00 :
									now.year + 8'h01;
							end
						end
					end
				end
			end
		end
	end

	// ********************************************************************
	// Dividers and strobes
	// ********************************************************************
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			div       <= 32'h0000_0000;
			ms_cnt    <= 10'h000;
			sec3      <= 2'h0;
			sec5      <= 3'h0;
			now       <= mfh_pkg::CAL_RESET;
			tick_fast <= 1'b0;
			tick_harm <= 1'b0;
			tick_slow <= 1'b0;
		end
		else
		begin
			now <= next_now;
			div <= ms_tick ? 32'h0000_0000 : div + 32'h0000_0001;
			if (ms_tick)
				ms_cnt <= sec_tick ? 10'h000 : ms_cnt + 10'h001;
			if (sec_tick)
			begin
				sec3 <= harm_hit ? 2'h0 : sec3 + 2'h1;
				sec5 <= slow_hit ? 3'h0 : sec5 + 3'h1;
			end
			tick_fast <= sec_tick;
			tick_harm <= sec_tick && harm_hit;
			tick_slow <= sec_tick && slow_hit;
		end
	end
endmodule

// *** src/mfh_function_handler.sv ***
// Slave-side function dispatcher: takes checked request frames, builds
// replies with their checksum and queues them in a reply FIFO.
// Assumes the framer below strips and checks the request checksum and
// marks the last byte of each frame; the far end drives one master.
//
// Functional notes
// - Codes 3 and 4 return the requested run of holding or input words.
// - Code 43 subfunction 14 returns identification data.
// - Time query echoes header and reserved byte, then current record.
// - Read reply: address, code, byte count twice words, words high first.
// - Time set: code 43/16, reserved, unused, date fields, msec word.
// - Calendar is updated before the echo reply starts.
// - Impossible date or time is answered with a zeroed record.
// - Code 100/4 returns up to one hundred scattered holding words.
// - Measurement strobes pulse every 1 s, 3 s and 5 s.
// - Non-measurement words are read live, changing with their source.
// - Dataset and module copies share the same refresh strobe.
// - Request address equals register number minus one.
// - Nothing is ever answered to address zero.
// - Frame is address, code, data, CRC16; at most 256 bytes.
`timescale 1ns/1ps
module mfh_function_handler #(
	parameter int          TICK_CYCLES = mfh_pkg::TICK_CYCLES,
	// Identification object value; arbitrary.
	parameter logic [31:0] ID_WORD     = 32'h0000_0001
) (
	// System
	input  wire logic        clock,
	input  wire logic        resetn,
	// Own slave address
	input  wire logic [7:0]  slave_addr,
	// Request bytes
	input  wire logic        rx_valid,
	input  wire logic [7:0]  rx_data,
	input  wire logic        rx_last,
	output logic             rx_ready,
	// Reply bytes
	output logic             tx_valid,
	output logic [7:0]       tx_data,
	output logic             tx_last,
	input  wire logic        tx_ready,
	// Register read port
	output logic             reg_req,
	output logic             reg_input_space,
	output logic [15:0]      reg_addr,
	input  wire logic        reg_ack,
	input  wire logic [15:0] reg_rdata,
	// Refresh strobes and calendar
	output logic             refresh_fast,
	output logic             refresh_harm,
	output logic             refresh_slow,
	output mfh_pkg::mfh_cal_s calendar_time_record
);
	// ********************************************************************
	// Storage
	// ********************************************************************
	mfh_pkg::mfh_state_e state;
	mfh_pkg::mfh_state_e next_state;
	logic [7:0]          rxbuf [0:255];
	logic [8:0]          rx_cnt;
	logic                rx_over;
	logic [7:0]          k;
	logic [7:0]          w;
	logic [3:0]          bj;
	logic [15:0]         crc;
	logic [15:0]         word_val;
	logic [79:0]         body;
	logic                rep_exc;
	logic [7:0]          rep_code;
	logic                rep_count;
	logic                rep_scat;
	logic [2:0]          rep_hdr;
	logic [7:0]          rep_words;
	logic [3:0]          rep_body;

	mfh_stream_if #(.W(mfh_pkg::FIFO_W)) q_in ();
	mfh_stream_if #(.W(mfh_pkg::FIFO_W)) q_out ();

	// ********************************************************************
	// Request decode
	// ********************************************************************
	wire [7:0]  fc       = rxbuf[1];
	wire        is_read  = fc == mfh_pkg::FC_RD_HOLD ||
		fc == mfh_pkg::FC_RD_INPUT;
	wire        is_mei   = fc == mfh_pkg::FC_MEI;
	wire        is_ident = is_mei && rxbuf[2] == mfh_pkg::SUB_IDENT;
	wire        is_get   = is_mei && rxbuf[2] == mfh_pkg::SUB_GET_TIME;
	wire        is_set   = is_mei && rxbuf[2] == mfh_pkg::SUB_SET_TIME;
	wire        is_scat  = fc == mfh_pkg::FC_SCATTER &&
		rxbuf[3] == mfh_pkg::SUB_SCATTER;
	wire [15:0] rd_start = {rxbuf[2], rxbuf[3]};
	wire [15:0] rd_count = {rxbuf[4], rxbuf[5]};
	wire        rd_bad   = rd_count == 16'h0000 ||
		rd_count > {8'h00, mfh_pkg::MAX_READ};
	wire [7:0]  scat_n   = (rxbuf[2] - mfh_pkg::SCAT_FIXED) >> 1;
	wire        scat_bad = rxbuf[2] < mfh_pkg::SCAT_MIN_LEN ||
		scat_n > mfh_pkg::MAX_SCATTER;
	wire        known    = is_read || is_ident || is_get || is_set || is_scat;
	wire        bad_val  = is_read && rd_bad || is_scat && scat_bad;
	wire        d_exc    = !known || bad_val;

	mfh_pkg::mfh_cal_s set_rec;
	mfh_pkg::mfh_cal_s now;
	mfh_pkg::mfh_cal_s time_src;

	assign set_rec  = {rxbuf[5], rxbuf[6], rxbuf[7], rxbuf[8], rxbuf[9],
		rxbuf[10], rxbuf[11]};
	wire   set_ok   = mfh_pkg::cal_valid(set_rec);
	wire   bcast    = rxbuf[0] == mfh_pkg::BCAST_ADDR;
	wire   unicast  = rxbuf[0] == slave_addr && !bcast &&
		slave_addr <= mfh_pkg::ADDR_LAST;
	wire   cal_load = state == mfh_pkg::S_DECODE && is_set && set_ok &&
		(unicast || bcast);
	assign time_src = is_get ? now : (set_ok ? set_rec : '0);

	wire [2:0] d_hdr   = d_exc || is_read ? mfh_pkg::HDR_SHORT :
		(is_scat ? mfh_pkg::HDR_SCAT : mfh_pkg::HDR_MEI);
	wire [7:0] d_words = d_exc ? 8'h00 : (is_read ? rd_count[7:0] :
		(is_scat ? scat_n : 8'h00));
	wire [3:0] d_body  = d_exc ? 4'h0 : (is_ident ? mfh_pkg::BODY_IDENT :
		(is_get || is_set ? mfh_pkg::BODY_TIME : 4'h0));
	wire [79:0] d_bodyv = is_ident ? {mfh_pkg::ID_CONFORM, 8'h00, 8'h00,
		mfh_pkg::ID_NOBJ, rxbuf[4], mfh_pkg::ID_OBJ_LEN, ID_WORD} :
		{8'h00, time_src, 16'h0000};

	// ********************************************************************
	// Reply byte selection
	// ********************************************************************
	wire [7:0] hdr_byte = (k == 8'h00) ? rxbuf[0] :
		(k == 8'h01) ? (rep_exc ? (fc | mfh_pkg::EXC_FLAG) : fc) :
		rep_exc ? rep_code :
		rep_count ? {rep_words[6:0], 1'b0} : rxbuf[k];
	wire sending = state == mfh_pkg::S_HDR || state == mfh_pkg::S_WHI ||
		state == mfh_pkg::S_WLO || state == mfh_pkg::S_BODY ||
		state == mfh_pkg::S_CRCL || state == mfh_pkg::S_CRCH;
	wire push = sending && q_in.ready;
	wire [7:0] push_byte = (state == mfh_pkg::S_HDR) ? hdr_byte :
		(state == mfh_pkg::S_WHI) ? word_val[15:8] :
		(state == mfh_pkg::S_WLO) ? word_val[7:0] :
		(state == mfh_pkg::S_BODY) ? body[79:72] :
		(state == mfh_pkg::S_CRCL) ? crc[7:0] : crc[15:8];

	assign q_in.valid = sending;
	assign q_in.data  = {state == mfh_pkg::S_CRCH, push_byte};

	// Next word address; the request address is used as is, so register
	// number n is reached by the address n minus one.
	wire [7:0]  fetch_w  = (state == mfh_pkg::S_WLO) ? 8'(w + 8'h01) : 8'h00;
	wire [7:0]  scat_idx = 8'(mfh_pkg::SCAT_FIRST + {fetch_w[6:0], 1'b0});
	wire [15:0] next_addr = rep_scat ?
		{rxbuf[scat_idx], rxbuf[8'(scat_idx + 8'h01)]} :
		16'(rd_start + {8'h00, fetch_w});
	wire last_hdr  = k == {5'h00, rep_hdr} - 8'h01;
	wire last_word = w == 8'(rep_words - 8'h01);
	wire after_hdr_fetch = rep_words != 8'h00;

	// ********************************************************************
	// Sequencer
	// ********************************************************************
	always_comb
	begin
		next_state = state;
		unique case (state)
			mfh_pkg::S_IDLE:
				if (rx_valid && rx_last)
					next_state = rx_over || rx_cnt == mfh_pkg::FRAME_MAX ?
						mfh_pkg::S_IDLE : mfh_pkg::S_DECODE;
			mfh_pkg::S_DECODE:
				next_state = unicast ? mfh_pkg::S_HDR :
					mfh_pkg::S_IDLE;
			mfh_pkg::S_HDR:
				if (push && last_hdr)
					next_state = after_hdr_fetch ? mfh_pkg::S_FETCH :
						(rep_body != 4'h0 ? mfh_pkg::S_BODY :
						mfh_pkg::S_CRCL);
			mfh_pkg::S_FETCH:
				if (reg_ack)
					next_state = mfh_pkg::S_WHI;
			mfh_pkg::S_WHI:
				if (push)
					next_state = mfh_pkg::S_WLO;
			mfh_pkg::S_WLO:
				if (push)
					next_state = last_word ? mfh_pkg::S_CRCL :
						mfh_pkg::S_FETCH;
			mfh_pkg::S_BODY:
				if (push && bj == 4'(rep_body - 4'h1))
					next_state = mfh_pkg::S_CRCL;
			mfh_pkg::S_CRCL:
				if (push)
					next_state = mfh_pkg::S_CRCH;
			mfh_pkg::S_CRCH:
				if (push)
					next_state = mfh_pkg::S_IDLE;
		endcase
	end

	assign rx_ready = state == mfh_pkg::S_IDLE;
	assign reg_req  = state == mfh_pkg::S_FETCH;

	// Bytes past 256 set the overflow flag and the frame is dropped.
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			state   <= mfh_pkg::S_IDLE;
			rx_cnt  <= 9'h000;
			rx_over <= 1'b0;
		end
		else
		begin
			state <= next_state;
			if (rx_valid && rx_ready)
			begin
				rx_cnt  <= rx_last ? 9'h000 : 9'(rx_cnt + 9'h001);
				rx_over <= rx_last ? 1'b0 :
					rx_over || rx_cnt == mfh_pkg::FRAME_MAX;
			end
		end
	end

	always_ff @(posedge clock)
	begin
		if (rx_valid && rx_ready && rx_cnt != mfh_pkg::FRAME_MAX)
			rxbuf[rx_cnt[7:0]] <= rx_data;
	end

	// ********************************************************************
	// Reply context
	// ********************************************************************
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			rep_exc         <= 1'b0;
			rep_code        <= 8'h00;
			rep_count       <= 1'b0;
			rep_scat        <= 1'b0;
			rep_hdr         <= mfh_pkg::HDR_SHORT;
			rep_words       <= 8'h00;
			rep_body        <= 4'h0;
			body            <= '0;
			reg_input_space <= 1'b0;
		end
		else if (state == mfh_pkg::S_DECODE)
		begin
			rep_exc   <= d_exc;
			rep_code  <= known ? mfh_pkg::EXC_ILL_VALUE :
				mfh_pkg::EXC_ILL_FUNC;
			rep_count <= is_read && !d_exc;
			rep_scat  <= is_scat;
			rep_hdr   <= d_hdr;
			rep_words <= d_words;
			rep_body  <= d_body;
			body      <= d_bodyv;
			reg_input_space <= fc == mfh_pkg::FC_RD_INPUT;
		end
		else if (state == mfh_pkg::S_BODY && push)
			body <= {body[71:0], 8'h00};
	end

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			k        <= 8'h00;
			w        <= 8'h00;
			bj       <= 4'h0;
			crc      <= mfh_pkg::CRC_INIT;
			word_val <= 16'h0000;
			reg_addr <= 16'h0000;
		end
		else
		begin
			if (state == mfh_pkg::S_DECODE)
			begin
				k   <= 8'h00;
				w   <= 8'h00;
				bj  <= 4'h0;
				crc <= mfh_pkg::CRC_INIT;
			end
			if (push && state != mfh_pkg::S_CRCL &&
				state != mfh_pkg::S_CRCH)
				crc <= mfh_pkg::crc_step(crc, push_byte);
			if (push && state == mfh_pkg::S_HDR)
				k <= 8'(k + 8'h01);
			if (push && state == mfh_pkg::S_BODY)
				bj <= 4'(bj + 4'h1);
			if (push && state == mfh_pkg::S_WLO)
				w <= 8'(w + 8'h01);
			if (next_state == mfh_pkg::S_FETCH &&
				state != mfh_pkg::S_FETCH)
				reg_addr <= next_addr;
			if (state == mfh_pkg::S_FETCH && reg_ack)
				word_val <= reg_rdata;
		end
	end

	// ********************************************************************
	// Calendar, refresh strobes and reply queue
	// ********************************************************************
	// One strobe per category feeds every copy of a value, so a dataset
	// word and its module word can never drift apart.
	mfh_clock #(.TICK_CYCLES(TICK_CYCLES)) u_clock (
		.clock     (clock),
		.resetn    (resetn),
		.load      (cal_load),
		.load_rec  (set_rec),
		.now       (now),
		.tick_fast (refresh_fast),
		.tick_harm (refresh_harm),
		.tick_slow (refresh_slow)
	);

	assign calendar_time_record = now;

	mfh_fifo #(.WIDTH(mfh_pkg::FIFO_W), .DEPTH(mfh_pkg::FIFO_DEPTH)) u_fifo (
		.clock  (clock),
		.resetn (resetn),
		.wr     (q_in),
		.rd     (q_out)
	);

	assign tx_valid    = q_out.valid;
	assign tx_data     = q_out.data[7:0];
	assign tx_last     = q_out.data[8];
	assign q_out.ready = tx_ready;
endmodule

// *** verif/mfh_checker.sv ***
// Port checks of the function dispatcher, bound to its top module.
// Assumes TICK_CYCLES is handed on from the bound instance.
`timescale 1ns/1ps
module mfh_checker #(
	parameter int TICK_CYCLES = 4
) (
	// System and request side
	input wire logic        clock,
	input wire logic        resetn,
	input wire logic        rx_valid,
	input wire logic        rx_last,
	input wire logic        rx_ready,
	// Reply side and register port
	input wire logic        tx_valid,
	input wire logic [7:0]  tx_data,
	input wire logic        tx_ready,
	input wire logic        reg_req,
	input wire logic        reg_ack,
	input wire logic [15:0] reg_addr,
	// Strobes
	input wire logic        refresh_fast,
	input wire logic        refresh_harm,
	input wire logic        refresh_slow
);
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	// The first strobe after reset is skipped, its phase is not fixed.
	int   gap;
	logic seen;
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			gap  <= 0;
			seen <= 1'b0;
		end
		else
		begin
			gap  <= refresh_fast ? 0 : gap + 1;
			seen <= seen | refresh_fast;
		end
	end
	addr_hold_a: assert property (
		reg_req && !reg_ack |=> reg_req && $stable(reg_addr))
		else $error("fetch address moved");
	ack_drop_a: assert property (
		reg_req && reg_ack |=> !reg_req) else $error("fetch held");
	fetch_busy_a: assert property (
		reg_req |-> !rx_ready) else $error("ready while fetching");
	frame_close_a: assert property (
		rx_valid && rx_ready && rx_last |=> !rx_ready)
		else $error("ready after frame end");
	tx_hold_a: assert property (
		tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
		else $error("reply byte lost");
	tx_drop_a: assert property (
		$fell(tx_valid) |-> $past(tx_ready)) else $error("valid dropped");
	fast_period_a: assert property (
		refresh_fast && seen |-> gap == 1000 * TICK_CYCLES - 1)
		else $error("fast strobe period wrong");
	harm_align_a: assert property (
		refresh_harm |-> refresh_fast) else $error("strobes out of step");
	slow_align_a: assert property (
		refresh_slow |-> refresh_fast) else $error("slow strobe out of step");
	cover property (reg_ack);
	cover property (rx_valid && rx_ready && rx_last);
	cover property (tx_valid && !tx_ready);
	cover property (refresh_harm);
endmodule

bind mfh_function_handler mfh_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
	.clock(clock), .resetn(resetn), .rx_valid(rx_valid),
	.rx_last(rx_last), .rx_ready(rx_ready), .tx_valid(tx_valid),
	.tx_data(tx_data), .tx_ready(tx_ready), .reg_req(reg_req),
	.reg_ack(reg_ack), .reg_addr(reg_addr),
	.refresh_fast(refresh_fast), .refresh_harm(refresh_harm),
	.refresh_slow(refresh_slow));

// *** verif/mfh_reg_model.sv ***
// Register source answering the dispatcher's fetches.
// Assumes one clock; answers alternate between prompt and three waits.
`timescale 1ns/1ps
module mfh_reg_model (
	// System
	input  wire logic        clock,
	input  wire logic        resetn,
	// Register read port
	input  wire logic        reg_req,
	input  wire logic        reg_input_space,
	input  wire logic [15:0] reg_addr,
	output logic             reg_ack,
	output logic [15:0]      reg_rdata
);
	logic [1:0] waits;
	logic       slow;
	always @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			reg_ack   <= 1'b0;
			reg_rdata <= 16'h0000;
			waits     <= 2'h0;
			slow      <= 1'b0;
		end
		else if (reg_ack)
		begin
			// Stale data is scrambled so nothing can reuse it by luck.
			reg_ack   <= 1'b0;
			reg_rdata <= ~reg_rdata;
		end
		else if (reg_req && waits == {slow, slow})
		begin
			reg_ack   <= 1'b1;
			reg_rdata <= reg_addr ^ (reg_input_space ? 16'h5a5a : 16'ha5a5);
			waits     <= 2'h0;
			slow      <= ~slow;
		end
		else if (reg_req)
			waits <= waits + 2'h1;
	end
endmodule

// *** verif/tb_top.sv ***
// Self-checking bench of the function dispatcher.
// Assumes the checker is bound and the register model answers.
`timescale 1ns/1ps
module tb_top;
	logic clock = 0, resetn = 0, rx_valid = 0, rx_last = 0, tx_ready = 0;
	logic [7:0]  slave_addr = 8'h2f, rx_data = 8'h00, tx_data;
	logic        rx_ready, tx_valid, tx_last, reg_req, reg_input_space;
	logic        reg_ack;
	logic [15:0] reg_addr, reg_rdata;
	mfh_pkg::mfh_cal_s calendar_time_record;
	int n_fail = 0, cmp_count = 0;
	always #10 clock = ~clock;
	mfh_function_handler #(.TICK_CYCLES(4)) DUT (.clock(clock),
		.resetn(resetn), .slave_addr(slave_addr), .rx_valid(rx_valid),
		.rx_data(rx_data), .rx_last(rx_last), .rx_ready(rx_ready),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
		.tx_ready(tx_ready), .reg_req(reg_req),
		.reg_input_space(reg_input_space), .reg_addr(reg_addr),
		.reg_ack(reg_ack), .reg_rdata(reg_rdata), .refresh_fast(),
		.refresh_harm(), .refresh_slow(),
		.calendar_time_record(calendar_time_record));
	mfh_reg_model PARTNER (.clock(clock), .resetn(resetn),
		.reg_req(reg_req), .reg_input_space(reg_input_space),
		.reg_addr(reg_addr), .reg_ack(reg_ack), .reg_rdata(reg_rdata));
	task automatic check(string nm, logic [39:0] seen, logic [39:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic send(logic [7:0] q[$]);
		foreach (q[i])
		begin
			rx_valid <= 1'b1;
			rx_data  <= q[i];
			rx_last  <= (i == q.size() - 1);
			@(negedge clock);
			while (rx_ready !== 1'b1) @(negedge clock);
			@(posedge clock);
		end
		rx_valid <= 1'b0;
		rx_last  <= 1'b0;
	endtask
	// The drain stalls a cycle per byte so the reply queue backs up.
	task automatic recv(logic [7:0] q[$]);
		logic [15:0] c;
		c = 16'hffff;
		foreach (q[i])
		begin
			c = c ^ {8'h00, q[i]};
			repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
		end
		q.push_back(c[7:0]);
		q.push_back(c[15:8]);
		foreach (q[i])
		begin
			@(negedge clock);
			while (tx_valid !== 1'b1) @(negedge clock);
			check("reply byte", tx_data, q[i]);
			check("last flag", tx_last, i == q.size() - 1);
			@(posedge clock);
			tx_ready <= 1'b1;
			@(posedge clock);
			tx_ready <= 1'b0;
		end
	endtask
	task automatic t_words(logic [7:0] fc, logic [7:0] n, logic [15:0] m);
		logic [7:0]  r[$];
		logic [15:0] w;
		send('{8'h2f, fc, 8'h52, 8'h2c, 8'h00, n});
		r = '{8'h2f, fc, {n[6:0], 1'b0}};
		for (int k = 0; k < n; k++)
		begin
			w = (16'h522c + k[15:0]) ^ m;
			r.push_back(w[15:8]);
			r.push_back(w[7:0]);
		end
		repeat (100) @(posedge clock);
		recv(r);
	endtask
	task automatic t_scatter;
		send('{8'h2f, 8'h64, 8'h06, 8'h04, 8'h55, 8'h02, 8'h97, 8'h02, 8'h99});
		recv('{8'h2f, 8'h64, 8'h06, 8'h04, 8'h55, 8'ha7, 8'h32, 8'ha7, 8'h3c});
	endtask
	task automatic t_ident;
		send('{8'h2f, 8'h2b, 8'h0e, 8'h01, 8'h00});
		recv('{8'h2f, 8'h2b, 8'h0e, 8'h01, 8'h01, 8'h00, 8'h00, 8'h01, 8'h00,
			8'h04, 8'h00, 8'h00, 8'h00, 8'h01});
	endtask
	task automatic t_unknown;
		send('{8'h2f, 8'h07, 8'h00});
		recv('{8'h2f, 8'h87, 8'h01});
	endtask
	task automatic t_set;
		send('{8'h2f, 8'h2b, 8'h10, 8'h00, 8'h00, 8'h0e, 8'h0a, 8'h02, 8'h0e,
			8'h20, 8'h0d, 8'hac});
		recv('{8'h2f, 8'h2b, 8'h10, 8'h00, 8'h00, 8'h0e, 8'h0a, 8'h02, 8'h0e,
			8'h20, 8'h0d, 8'hac});
		check("date", calendar_time_record[55:16], 40'h0e0a020e20);
	endtask
	task automatic t_bad_set;
		send('{8'h2f, 8'h2b, 8'h10, 8'h00, 8'h00, 8'h0e, 8'h0d, 8'h02, 8'h0e,
			8'h20, 8'h0d, 8'hac});
		recv('{8'h2f, 8'h2b, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
			8'h00, 8'h00, 8'h00});
		check("kept date", calendar_time_record[55:16], 40'h0e0a020e20);
	endtask
	task automatic t_bcast;
		send('{8'h00, 8'h2b, 8'h10, 8'h00, 8'h00, 8'h15, 8'h01, 8'h1f, 8'h17,
			8'h3b, 8'h00, 8'h00});
		repeat (300) @(negedge clock);
		check("silent", tx_valid, 1'b0);
		check("bcast date", calendar_time_record[55:16], 40'h15011f173b);
	endtask
	// Sent straight after reset, so the record is the reset value plus 1 ms.
	task automatic t_get;
		send('{8'h2f, 8'h2b, 8'h0f, 8'h00});
		recv('{8'h2f, 8'h2b, 8'h0f, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00,
			8'h00, 8'h00, 8'h01});
	endtask
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial
	begin
		repeat (40000) @(posedge clock);
		n_fail++;
		complete_run;
	end
	initial
	begin
		repeat (20) @(posedge clock);
		resetn <= 1'b1;
		@(posedge clock);
		t_words(8'h03, 8'h0c, 16'ha5a5);
		t_words(8'h04, 8'h01, 16'h5a5a);
		t_scatter;
		t_ident;
		t_unknown;
		t_set;
		t_bad_set;
		t_bcast;
		@(posedge clock);
		resetn <= 1'b0;
		@(posedge clock);
		resetn <= 1'b1;
		t_get;
		t_set;
		repeat (20100) @(posedge clock);
		complete_run;
	end
endmodule
